// ===== logic/can_rx_map.vh
// Register offsets, field positions and reset values for the CAN receive block.
`ifndef CAN_RX_MAP_VH
`define CAN_RX_MAP_VH
`define OFF_TX_ID_HIGH 12'h000
`define OFF_TX_ID_LOW 12'h004
`define OFF_TX_EXT_ID_HIGH 12'h008
`define OFF_CONTROL 12'h00C
`define OFF_STATUS 12'h010
`define OFF_ENH_CONTROL 12'h014
`define OFF_IO_CONTROL 12'h018
`define OFF_RX_FULL 12'h01C
`define OFF_FILTER_EN 12'h020
`define OFF_BUF_TX 12'h024
`define OFF_MASK 12'h028
`define OFF_FILTER_BASE 12'h040
`define OFF_ASSIGN_BASE 12'h080
`define BIT_EXT_ID_ENABLE 3
`define BIT_WATERMARK_SEL 0
`define BIT_FIFO_MODE 1
`define BIT_TIMESTAMP_EN 2
`define BIT_CAPTURE_EN 4
`define CODE_FIFO_RX 5'h10
`define CODE_NONE 5'h00
`define CODE_WATERMARK 5'h11
`define RESET_BYTE 8'h00
`endif

// ===== logic/can_filter_table.v
// Small memory holding acceptance filter words with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module can_filter_table #(
  parameter WIDTH = 29,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [WIDTH-1:0] rdata_o
);
  // Storage words; contents are undefined until software writes them.
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write port and registered read port share the one clock.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// ===== logic/can_tx_id_rx_fifo_timestamp.v
// CAN transmit identifier registers, receive acceptance, FIFO and time-stamp.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.vh"
module can_tx_id_rx_fifo_timestamp #(
  parameter NBUF = 8,
  parameter NFILT = 16,
  parameter IDW = 29
) (
  input wire clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire msg_valid_i,
  input wire [IDW-1:0] msg_id_i,
  input wire msg_ext_i,
  input wire normal_capture_i,
  output reg capture_o,
  output reg rx_store_o,
  output reg [2:0] rx_store_buf_o,
  output reg fifo_empty_o,
  output reg watermark_o,
  output reg [IDW-1:0] tx_id_o,
  output reg tx_ext_o
);
  // Transmit identifier byte registers.
  reg [7:0] id_high_q;
  reg [2:0] id_low_top_q;
  reg ext_en_q;
  reg [1:0] id_low_bot_q;
  reg [7:0] ext_high_q;
  // Read pointer, interrupt code and full flags.
  reg [3:0] read_ptr_q;
  reg [2:0] write_ptr_q;
  reg [4:0] int_code_q;
  reg [NBUF-1:0] rx_full_q;
  // Configuration bits set by software.
  reg fifo_mode_q;
  reg watermark_sel_q;
  reg timestamp_en_q;
  reg capture_en_q;
  reg [NFILT-1:0] filter_en_q;
  reg [5:0] buf_tx_q;
  reg [IDW-1:0] mask_q;
  // Per-filter buffer assignment, three bits each.
  reg [2:0] assign_q [0:NFILT-1];
  // Matching walk over the filter table, one filter per cycle.
  reg scan_q;
  // Five bits so that the walk can reach one step past the last filter.
  reg [4:0] scan_idx_q;
  reg [IDW-1:0] scan_id_q;
  reg [NBUF-1:0] hits_q;
  reg can_event_q;
  integer i;
  // Loop index of the combinational count, kept apart from the clocked one.
  integer j;
  // Filter whose word the table presents in this step of the walk.
  wire [3:0] prev_idx = scan_idx_q[3:0] - 4'h1;

  // Bus decode: the slave always answers in the access cycle.
  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_en = psel_i & penable_i & ~pwrite_i;
  wire filt_sel = (paddr_i[11:6] == 6'h01);
  wire asg_sel = (paddr_i[11:6] == 6'h02);
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Filter words live in the small memory; the scan reads them in order.
  wire [IDW-1:0] filt_word;
  can_filter_table #(.WIDTH(IDW), .DEPTH(NFILT), .AW(4)) u_filters (
    .clk_i(clk_i),
    .we_i(wr_en & filt_sel),
    .waddr_i(paddr_i[5:2]),
    .wdata_i(pwdata_i[IDW-1:0]),
    .raddr_i(scan_idx_q[3:0]),
    .rdata_o(filt_word)
  );

  // Each bit accepts when masked off or when filter and id agree.
  function id_match;
    input [IDW-1:0] mask;
    input [IDW-1:0] filt;
    input [IDW-1:0] id;
    begin
      id_match = &(~mask | ~(filt ^ id));
    end
  endfunction

  // FIFO length: two dedicated buffers plus programmable ones before a
  // transmit buffer.
  function [3:0] fifo_len;
    input [5:0] txb;
    integer k;
    reg stop;
    begin
      fifo_len = 4'h2;
      stop = 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        if (txb[k]) begin
          stop = 1'b1;
        end else if (!stop) begin
          fifo_len = fifo_len + 4'h1;
        end
      end
    end
  endfunction

  // Lowest set bit wins when several buffers would accept.
  function [3:0] lowest;
    input [NBUF-1:0] v;
    integer k;
    begin
      lowest = 4'h8;
      for (k = NBUF - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest = k[3:0];
        end
      end
    end
  endfunction

  wire [3:0] flen = fifo_len(buf_tx_q);
  // Count of full buffers within the FIFO span.
  reg [3:0] used;
  always @* begin
    used = 4'h0;
    for (j = 0; j < NBUF; j = j + 1) begin
      if (j < flen && rx_full_q[j]) begin
        used = used + 4'h1;
      end
    end
  end
  wire [3:0] free_cnt = flen - used;
  wire [3:0] pick = lowest(hits_q);
  wire ptr_full = rx_full_q[read_ptr_q[2:0]];

  // Next read or write pointer, wrapping at the FIFO length.
  function [2:0] wrap_inc;
    input [2:0] p;
    input [3:0] len;
    begin
      if ({1'b0, p} + 4'h1 >= len) begin
        wrap_inc = 3'h0;
      end else begin
        wrap_inc = p + 3'h1;
      end
    end
  endfunction

  // Register writes, acceptance scan and FIFO pointers.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      id_high_q <= `RESET_BYTE;
      id_low_top_q <= 3'h0;
      ext_en_q <= 1'b0;
      id_low_bot_q <= 2'h0;
      ext_high_q <= `RESET_BYTE;
      read_ptr_q <= 4'h0;
      write_ptr_q <= 3'h0;
      int_code_q <= `CODE_NONE;
      rx_full_q <= {NBUF{1'b0}};
      fifo_mode_q <= 1'b0;
      watermark_sel_q <= 1'b0;
      timestamp_en_q <= 1'b0;
      capture_en_q <= 1'b0;
      filter_en_q <= {NFILT{1'b0}};
      buf_tx_q <= 6'h00;
      mask_q <= {IDW{1'b0}};
      scan_q <= 1'b0;
      scan_idx_q <= 5'h00;
      scan_id_q <= {IDW{1'b0}};
      hits_q <= {NBUF{1'b0}};
      rx_store_o <= 1'b0;
      rx_store_buf_o <= 3'h0;
      can_event_q <= 1'b0;
      for (i = 0; i < NFILT; i = i + 1) begin
        assign_q[i] <= 3'h0;
      end
    end else begin
      rx_store_o <= 1'b0;
      can_event_q <= 1'b0;
      // Software writes; clearing a full flag happens before any set below.
      if (wr_en) begin
        case (paddr_i)
          `OFF_TX_ID_HIGH: begin
            id_high_q <= pwdata_i[7:0];
          end
          `OFF_TX_ID_LOW: begin
            id_low_top_q <= pwdata_i[7:5];
            ext_en_q <= pwdata_i[`BIT_EXT_ID_ENABLE];
            id_low_bot_q <= pwdata_i[1:0];
          end
          `OFF_TX_EXT_ID_HIGH: begin
            ext_high_q <= pwdata_i[7:0];
          end
          `OFF_ENH_CONTROL: begin
            watermark_sel_q <= pwdata_i[`BIT_WATERMARK_SEL];
            fifo_mode_q <= pwdata_i[`BIT_FIFO_MODE];
            timestamp_en_q <= pwdata_i[`BIT_TIMESTAMP_EN];
          end
          `OFF_IO_CONTROL: begin
            capture_en_q <= pwdata_i[`BIT_CAPTURE_EN];
          end
          `OFF_RX_FULL: begin
            // Write one to clear a flag.
            rx_full_q <= rx_full_q & ~pwdata_i[NBUF-1:0];
          end
          `OFF_FILTER_EN: begin
            filter_en_q <= pwdata_i[NFILT-1:0];
          end
          `OFF_BUF_TX: begin
            buf_tx_q <= pwdata_i[5:0];
          end
          `OFF_MASK: begin
            mask_q <= pwdata_i[IDW-1:0];
          end
          default: begin
            if (asg_sel) begin
              assign_q[paddr_i[5:2]] <= pwdata_i[2:0];
            end
          end
        endcase
      end
      // In FIFO mode the pointer leaves a buffer once its flag is clear.
      // A full FIFO has both pointers equal, so pending data also moves it.
      if (fifo_mode_q && !ptr_full &&
          (read_ptr_q[2:0] != write_ptr_q || used != 4'h0)) begin
        read_ptr_q <= {1'b0, wrap_inc(read_ptr_q[2:0], flen)};
      end
      // Start a scan when a message is presented and none is running.
      if (msg_valid_i && !scan_q) begin
        scan_q <= 1'b1;
        scan_idx_q <= 5'h00;
        scan_id_q <= msg_ext_i ? msg_id_i : {msg_id_i[10:0], 18'h00000};
        hits_q <= {NBUF{1'b0}};
      end else if (scan_q) begin
        // Memory data lag the index by one, so step 16 checks filter 15.
        scan_idx_q <= scan_idx_q + 5'h01;
        if (scan_idx_q != 5'h00 && filter_en_q[prev_idx] &&
            id_match(mask_q, filt_word, scan_id_q)) begin
          if (fifo_mode_q) begin
            hits_q[0] <= 1'b1;
          end else begin
            hits_q[assign_q[prev_idx]] <= 1'b1;
          end
        end
        if (scan_idx_q == 5'h10) begin
          scan_q <= 1'b0;
        end
      end
      // Store decision one cycle after the scan closes.
      if (!scan_q && hits_q != {NBUF{1'b0}}) begin
        hits_q <= {NBUF{1'b0}};
        if (fifo_mode_q) begin
          if (!rx_full_q[write_ptr_q]) begin
            rx_full_q[write_ptr_q] <= 1'b1;
            rx_store_buf_o <= write_ptr_q;
            rx_store_o <= 1'b1;
            can_event_q <= timestamp_en_q;
            write_ptr_q <= wrap_inc(write_ptr_q, flen);
            int_code_q <= `CODE_FIFO_RX;
          end
        end else if (!rx_full_q[pick[2:0]]) begin
          rx_full_q[pick[2:0]] <= 1'b1;
          rx_store_buf_o <= pick[2:0];
          rx_store_o <= 1'b1;
          can_event_q <= timestamp_en_q;
        end
      end
    end
  end

  // Status outputs, capture routing and transmit id assembly.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      fifo_empty_o <= 1'b1;
      watermark_o <= 1'b0;
      capture_o <= 1'b0;
      tx_id_o <= {IDW{1'b0}};
      tx_ext_o <= 1'b0;
    end else begin
      fifo_empty_o <= ~ptr_full;
      watermark_o <= fifo_mode_q &&
        (free_cnt == (watermark_sel_q ? 4'h4 : 4'h1));
      capture_o <= capture_en_q ? can_event_q : normal_capture_i;
      tx_ext_o <= ext_en_q;
      if (ext_en_q) begin
        tx_id_o <= {id_high_q, id_low_top_q, id_low_bot_q, ext_high_q,
                    8'h00};
      end else begin
        tx_id_o <= {18'h00000, id_high_q, id_low_top_q};
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    prdata_o = 32'h00000000;
    if (rd_en) begin
      case (paddr_i)
        `OFF_TX_ID_HIGH: prdata_o = {24'h000000, id_high_q};
        `OFF_TX_ID_LOW: prdata_o = {24'h000000, id_low_top_q, 1'b0,
                                    ext_en_q, 1'b0, id_low_bot_q};
        `OFF_TX_EXT_ID_HIGH: prdata_o = {24'h000000, ext_high_q};
        `OFF_CONTROL: prdata_o = {28'h0000000, read_ptr_q};
        `OFF_STATUS: prdata_o = {27'h0000000, int_code_q};
        `OFF_ENH_CONTROL: prdata_o = {29'h00000000, timestamp_en_q,
                                      fifo_mode_q, watermark_sel_q};
        `OFF_IO_CONTROL: prdata_o = {27'h0000000, capture_en_q, 4'h0};
        `OFF_RX_FULL: prdata_o = {{(32-NBUF){1'b0}}, rx_full_q};
        `OFF_FILTER_EN: prdata_o = {{(32-NFILT){1'b0}}, filter_en_q};
        `OFF_BUF_TX: prdata_o = {26'h0000000, buf_tx_q};
        `OFF_MASK: prdata_o = {{(32-IDW){1'b0}}, mask_q};
        default: begin
          if (asg_sel) begin
            prdata_o = {29'h00000000, assign_q[paddr_i[5:2]]};
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== sim/can_rx_props.sv
// Checker for the CAN identifier, acceptance and FIFO block.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.vh"
module can_rx_props #(parameter IDW = 29) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic msg_valid_i,
  input wire logic normal_capture_i,
  input wire logic capture_o,
  input wire logic rx_store_o,
  input wire logic fifo_empty_o,
  input wire logic watermark_o,
  input wire logic [IDW-1:0] tx_id_o,
  input wire logic tx_ext_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Ages since the last message and since the last store or write.
  logic [5:0] age_q;
  logic [2:0] evt_q;
  wire wr = psel_i && penable_i && pwrite_i;
  wire lo = wr && paddr_i == `OFF_TX_ID_LOW;
  // Saturating counters so that late causes still read as old.
  always @(posedge clk_i) begin
    if (!resetn_i || msg_valid_i) age_q <= 6'h00;
    else if (age_q != 6'h3F) age_q <= age_q + 6'h01;
    if (!resetn_i || wr || rx_store_o) evt_q <= 3'h0;
    else if (evt_q != 3'h7) evt_q <= evt_q + 3'h1;
  end
  store_delay_a: assert property (
    rx_store_o |-> age_q > 6'h0E && age_q < 6'h15) else $error("late store");
  store_pulse_a: assert property (
    rx_store_o |=> !rx_store_o) else $error("long store pulse");
  capture_cause_a: assert property (
    capture_o |-> $past(rx_store_o) || $past(rx_store_o, 2) ||
    $past(normal_capture_i) || $past(normal_capture_i, 2))
    else $error("capture without cause");
  empty_cause_a: assert property (
    $fell(fifo_empty_o) |-> rx_store_o || wr || evt_q < 3'h3)
    else $error("empty fell without store");
  mark_cause_a: assert property (
    $rose(watermark_o) |-> rx_store_o || wr || evt_q < 3'h3)
    else $error("watermark without cause");
  id_high_a: assert property (
    wr && paddr_i == `OFF_TX_ID_HIGH && tx_ext_o |->
    ##2 tx_id_o[IDW-1 -: 8] == $past(pwdata_i[7:0], 2)) else $error("id high");
  id_low_a: assert property (
    lo && pwdata_i[3] |-> ##2 tx_id_o[IDW-9 -: 3] == $past(pwdata_i[7:5], 2)
    && tx_id_o[IDW-12 -: 2] == $past(pwdata_i[1:0], 2)) else $error("id low");
  std_sel_a: assert property (
    lo |-> ##2 tx_ext_o == $past(pwdata_i[3], 2)) else $error("ext select");
  ext_high_a: assert property (
    wr && paddr_i == `OFF_TX_EXT_ID_HIGH && tx_ext_o |->
    ##2 tx_id_o[IDW-14 -: 8] == $past(pwdata_i[7:0], 2)) else $error("ext id");
  low_zero_a: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == `OFF_TX_ID_LOW |->
    !prdata_o[4] && !prdata_o[2]) else $error("reserved bits set");
  c_store: cover property (rx_store_o);
  c_mark: cover property ($rose(watermark_o));
  c_stamp: cover property (capture_o && $past(rx_store_o));
endmodule
bind can_tx_id_rx_fifo_timestamp can_rx_props #(.IDW(IDW)) props (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .msg_valid_i(msg_valid_i),
  .normal_capture_i(normal_capture_i), .capture_o(capture_o),
  .rx_store_o(rx_store_o), .fifo_empty_o(fifo_empty_o),
  .watermark_o(watermark_o), .tx_id_o(tx_id_o), .tx_ext_o(tx_ext_o));
`default_nettype wire

// ===== sim/can_node_model.sv
// Behavioural CAN node that hands received identifiers to the block.
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  input wire logic clk_i,
  output logic msg_valid_o,
  output logic [28:0] msg_id_o,
  output logic msg_ext_o
);
  logic busy_q = 1'b0;
  initial begin
    msg_valid_o = 1'b0;
    msg_id_o = 29'h0;
    msg_ext_o = 1'b0;
  end
  // Idle id lines toggle, so a stale id never passes for a fresh one.
  always @(posedge clk_i) if (!busy_q) msg_id_o <= ~msg_id_o;
  // One frame: a valid pulse with its id, then a quiet gap.
  task automatic send(input logic [28:0] id, input logic ext, input int gap);
    busy_q = 1'b1;
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_id_o <= id;
    msg_ext_o <= ext;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    busy_q <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== sim/can_tx_id_rx_fifo_timestamp_bench.sv
// Self-checking bench for the CAN identifier, acceptance and FIFO block.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.vh"
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module can_tx_id_rx_fifo_timestamp_bench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic normal_capture_i = 1'b0;
  wire [31:0] prdata_o;
  wire [28:0] mid, tx_id_o;
  wire [2:0] sbuf;
  wire pready_o, mval, mext, capture_o, store, empty, mark, tx_ext_o;
  int checks = 0, failures = 0, seed = 76, caps = 0, i;
  logic [31:0] rd_q;
  logic [2:0] exp_q[$];
  logic [2:0] eb;
  logic [7:0] hb;
  always #5 clk_i = ~clk_i;
  can_tx_id_rx_fifo_timestamp dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(), .msg_valid_i(mval), .msg_id_i(mid),
    .msg_ext_i(mext), .normal_capture_i(normal_capture_i),
    .capture_o(capture_o), .rx_store_o(store), .rx_store_buf_o(sbuf),
    .fifo_empty_o(empty), .watermark_o(mark), .tx_id_o(tx_id_o),
    .tx_ext_o(tx_ext_o));
  can_node_model node (.clk_i(clk_i), .msg_valid_o(mval), .msg_id_o(mid),
    .msg_ext_o(mext));
  // Every store is matched against the oldest expected buffer.
  always @(posedge clk_i) begin
    if (capture_o === 1'b1) caps++;
    if (store === 1'b1) begin
      eb = exp_q.size() > 0 ? exp_q.pop_front() : 3'hX;
      `CK("buffer", eb, sbuf)
    end
  end
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer; read data lands in rd_q.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      failures++;
      results();
    end
    rd_q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rx(input logic [28:0] id, input int b);
    if (b >= 0) exp_q.push_back(b[2:0]);
    node.send(id, 1'b1, 20);
  endtask
  task automatic rst;
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    apb(1'b1, `OFF_MASK, 32'h0);
    apb(1'b1, `OFF_FILTER_EN, 32'h1);
  endtask
  initial begin
    rst();
    `CK("empty", 1'b1, empty)
    hb = 8'($random(seed));
    apb(1'b1, `OFF_TX_ID_LOW, 32'hFF);
    apb(1'b1, `OFF_TX_ID_HIGH, {24'h0, hb});
    apb(1'b1, `OFF_TX_EXT_ID_HIGH, {24'h0, ~hb});
    apb(1'b0, `OFF_TX_ID_LOW, 32'h0);
    `CK("low", 8'hEB, rd_q[7:0])
    `CK("ext", 1'b1, tx_ext_o)
    `CK("high", hb, tx_id_o[28:21])
    `CK("mid", 5'h1F, tx_id_o[20:16])
    `CK("exth", ~hb, tx_id_o[15:8])
    apb(1'b1, `OFF_TX_ID_LOW, 32'h0);
    repeat (3) @(posedge clk_i);
    `CK("std", 1'b0, tx_ext_o)
    `CK("stdid", 29'(hb) << 3, tx_id_o)
    $display("test txid done");
    for (i = 0; i < 16; i++) begin
      apb(1'b1, `OFF_FILTER_EN, 32'h1 << i);
      apb(1'b1, `OFF_ASSIGN_BASE + 12'(4 * i), i % 8);
      rx(29'($random(seed)), i % 8);
      apb(1'b1, `OFF_RX_FULL, 32'hFF);
    end
    apb(1'b1, `OFF_FILTER_EN, 32'h8008);
    apb(1'b1, `OFF_ASSIGN_BASE + 12'h0C, 32'h4);
    apb(1'b1, `OFF_ASSIGN_BASE + 12'h3C, 32'h1);
    rx(29'h0ABCDEF, 1);
    apb(1'b1, `OFF_MASK, 32'h1FFFFFFF);
    apb(1'b1, `OFF_FILTER_BASE + 12'h3C, 32'h155);
    apb(1'b1, `OFF_FILTER_BASE + 12'h0C, 32'h2AA);
    apb(1'b1, `OFF_RX_FULL, 32'hFF);
    rx(29'h155, 1);
    rx(29'h154, -1);
    rx(29'h2AA, 4);
    $display("test accept done");
    rst();
    apb(1'b1, `OFF_ENH_CONTROL, 32'h3);
    for (i = 0; i < 9; i++) begin
      rx(29'($random(seed)), i < 8 ? i : -1);
      `CK("mark", 1'(i == 3), mark)
      if (i == 0) apb(1'b0, `OFF_STATUS, 32'h0);
      if (i == 0) `CK("code", 5'h10, rd_q[4:0])
    end
    apb(1'b0, `OFF_CONTROL, 32'h0);
    `CK("ptr", 4'h0, rd_q[3:0])
    apb(1'b1, `OFF_ENH_CONTROL, 32'h2);
    apb(1'b1, `OFF_RX_FULL, 32'h1);
    repeat (4) @(posedge clk_i);
    apb(1'b0, `OFF_CONTROL, 32'h0);
    `CK("ptr", 4'h1, rd_q[3:0])
    `CK("mark", 1'b1, mark)
    `CK("empty", 1'b0, empty)
    apb(1'b1, `OFF_RX_FULL, 32'hFE);
    repeat (12) @(posedge clk_i);
    `CK("empty", 1'b1, empty)
    apb(1'b0, `OFF_CONTROL, 32'h0);
    `CK("wrap", 4'h0, rd_q[3:0])
    $display("test fifo done");
    rst();
    apb(1'b1, `OFF_BUF_TX, 32'h1);
    apb(1'b1, `OFF_ENH_CONTROL, 32'h2);
    rx(29'($random(seed)), 0);
    rx(29'($random(seed)), 1);
    rx(29'($random(seed)), -1);
    normal_capture_i <= 1'b1;
    @(posedge clk_i);
    normal_capture_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CK("pass", 1, caps)
    apb(1'b1, `OFF_RX_FULL, 32'h3);
    apb(1'b1, `OFF_IO_CONTROL, 32'h10);
    apb(1'b1, `OFF_ENH_CONTROL, 32'h6);
    normal_capture_i <= 1'b1;
    rx(29'($random(seed)), 0);
    // Let the capture pulse reach the watcher before the count is read.
    repeat (2) @(posedge clk_i);
    `CK("stamp", 2, caps)
    `CK("pending", 0, exp_q.size())
    $display("test stamp done");
    results();
  end
endmodule
`default_nettype wire
